// file: logic/indicator_pkg.sv
/*
  Constants for the indicator display status logic.
  Assumes a 20 MHz system clock.
*/
package indicator_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned NUM_CHANNELS = 8;
  localparam int unsigned BAR_STEPS = 10;
  localparam int unsigned DWELL_MIN_S = 2;
  localparam int unsigned DWELL_MAX_S = 20;
  localparam int unsigned DWELL_RST_S = 5;
  localparam int unsigned SCROLL_MS = 500;
  localparam int unsigned TEXT_MAX = 16;
  localparam int unsigned TEXT_VIS = 8;
  localparam int unsigned CYC_PER_S = CLK_HZ;
  localparam int unsigned SCROLL_CYC = (CLK_HZ / 1000) * SCROLL_MS;
  localparam logic [7:0] STATUS_GOOD_MIN = 8'h80;
  localparam logic [7:0] STATUS_UNC_MIN = 8'h40;
  localparam logic [7:0] ADDR_NONE = 8'h00;
  localparam logic [4:0] DWELL_RST = 5'h05;
  localparam logic [4:0] DWELL_MIN = 5'h02;
  localparam logic [4:0] DWELL_MAX = 5'h14;
  localparam logic [3:0] SEL_MASK = 4'h8;
  localparam logic [3:0] SEL_DWELL = 4'h9;
  localparam logic [3:0] SEL_MODE = 4'ha;
  localparam logic [7:0] MASK_RST = 8'h01;
  typedef enum logic [1:0] {QUAL_GOOD, QUAL_UNCERTAIN, QUAL_BAD} quality_t;
  typedef enum logic {MODE_LISTENER, MODE_FBLOCK} source_mode_t;
endpackage : indicator_pkg

// file: logic/pin_sync.sv
/*
  Three-stage synchroniser for a slow pin with agreement filter.
  Assumes the pin changes far slower than the clock.
*/
module pin_sync
  import indicator_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // pin in, filtered level out
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;
endmodule : pin_sync

// file: logic/indicator_display.sv
/*
  Display control for a bus-powered field indicator: bar graph, value
  area, text area, status symbols, channel binding, write protection.
  Assumes the protocol stack delivers values, status bytes and
  parameter write requests as same-clock strobes.
*/
// Functional notes
// - bar graph steps in tenths of range
// - bar 0..100 with under/over arrows
// - cycle up to eight values, 2-20 s
// - text max 16 chars, scrolls when long
// - status >= 0x80 lights no symbol
// - status 0x40..0x7f lights uncertain symbol
// - status below 0x40 shows BAD, channel
// - bad channel also shown in text
// - listener: bind eight channels to addresses
// - block mode shows assigned block parameter
// - write protect rejects every parameter change
// - lock status readable from switch
// - switch on enables protection
module indicator_display
  import indicator_pkg::*;
#(
  parameter int unsigned NCH = NUM_CHANNELS,
  parameter int unsigned CYC_SEC = CYC_PER_S,
  parameter int unsigned SCR_CYC = SCROLL_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // write-protect switch pin
  input wire logic wp_switch_i,
  // published values from the bus
  input wire logic pub_valid_i,
  input wire logic [7:0] pub_addr_i,
  input wire logic [15:0] pub_value_i,
  input wire logic [7:0] pub_status_i,
  input wire logic comm_active_i,
  // function-block parameter feed
  input wire logic fb_valid_i,
  input wire logic [2:0] fb_chan_i,
  input wire logic [15:0] fb_value_i,
  input wire logic [7:0] fb_status_i,
  // parameter write requests
  input wire logic par_wr_i,
  input wire logic [3:0] par_sel_i,
  input wire logic [7:0] par_data_i,
  // range and text
  input wire logic [15:0] range_lo_i,
  input wire logic [15:0] range_hi_i,
  input wire logic [4:0] text_len_i,
  // outputs
  output logic [3:0] bar_segs_o,
  output logic arrow_under_o,
  output logic arrow_over_o,
  output logic [15:0] seg7_value_o,
  output logic seg7_bad_o,
  output logic [2:0] seg7_chan_o,
  output logic [4:0] text_pos_o,
  output logic text_show_chan_o,
  output logic [2:0] text_chan_o,
  output logic sym_uncertain_o,
  output logic sym_locked_o,
  output logic sym_comm_o,
  output logic write_lock_o,
  output logic par_rej_o,
  output logic par_ack_o,
  output logic [7:0] seen_addr_o,
  output logic seen_valid_o
);
  typedef struct packed {
    logic [NCH-1:0][7:0] bind_addr;
    logic [NCH-1:0][15:0] value;
    logic [NCH-1:0][7:0] status;
    logic [7:0] shown_mask;
    logic mode;
    logic [4:0] dwell_s;
    logic [2:0] cur;
    logic [4:0] sec_cnt;
    logic [24:0] cyc_cnt;
    logic [23:0] scr_cnt;
    logic [4:0] text_pos;
    logic [3:0] bar;
    logic under;
    logic over;
    logic [15:0] seg_val;
    logic bad;
    logic uncertain;
    logic lock;
    logic comm;
    logic rej;
    logic ack;
    logic [7:0] seen_addr;
    logic seen_valid;
  } disp_state_t;

  disp_state_t st;
  disp_state_t next_st;
  logic wp_level;
  ////////////////////////////////////////////////////////////////////
  pin_sync u_wp_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(wp_switch_i),
    .level_o(wp_level)
  );
  function automatic quality_t classify(input logic [7:0] s);
    if (s >= STATUS_GOOD_MIN) begin
      classify = QUAL_GOOD;
    end else if (s >= STATUS_UNC_MIN) begin
      classify = QUAL_UNCERTAIN;
    end else begin
      classify = QUAL_BAD;
    end
  endfunction : classify
  function automatic logic [3:0] bar_steps(input logic [15:0] v, lo, hi);
    logic [31:0] num;
    logic [31:0] span;
    logic [31:0] q;
    num = 32'({16'h0000, v - lo}) * 32'(BAR_STEPS);
    span = {16'h0000, hi - lo};
    q = (span == 32'h0) ? 32'h0 : num / span;
    bar_steps = (q > 32'(BAR_STEPS)) ? 4'(BAR_STEPS) : q[3:0];
  endfunction : bar_steps
  ////////////////////////////////////////////////////////////////////
  quality_t q_cur;
  logic [15:0] v_cur;
  always_comb begin
    next_st = st;
    next_st.rej = 1'b0;
    next_st.ack = 1'b0;
    next_st.seen_valid = 1'b0;
    next_st.lock = wp_level;
    next_st.comm = comm_active_i;
    // parameter writes, blocked under protection
    if (par_wr_i) begin
      if (wp_level) begin
        next_st.rej = 1'b1;
      end else begin
        next_st.ack = 1'b1;
        if (par_sel_i < 4'(NCH)) begin
          next_st.bind_addr[par_sel_i[2:0]] = par_data_i;
        end else if (par_sel_i == SEL_MASK) begin
          next_st.shown_mask = par_data_i;
        end else if (par_sel_i == SEL_DWELL) begin
          if (par_data_i[4:0] < DWELL_MIN) begin
            next_st.dwell_s = DWELL_MIN;
          end else if (par_data_i[4:0] > DWELL_MAX || par_data_i[7:5] != 3'h0) begin
            next_st.dwell_s = DWELL_MAX;
          end else begin
            next_st.dwell_s = par_data_i[4:0];
          end
        end else if (par_sel_i == SEL_MODE) begin
          next_st.mode = par_data_i[0];
        end
      end
    end
    // value capture per mode
    if (st.mode == MODE_LISTENER) begin
      if (pub_valid_i) begin
        next_st.seen_addr = pub_addr_i;
        next_st.seen_valid = 1'b1;
        for (int i = 0; i < NCH; i++) begin
          if (st.bind_addr[i] != ADDR_NONE && st.bind_addr[i] == pub_addr_i) begin
            next_st.value[i] = pub_value_i;
            next_st.status[i] = pub_status_i;
          end
        end
      end
    end else if (fb_valid_i) begin
      next_st.value[fb_chan_i] = fb_value_i;
      next_st.status[fb_chan_i] = fb_status_i;
    end
    // dwell timer, advances to next enabled channel
    if (st.cyc_cnt == 25'(CYC_SEC - 1)) begin
      next_st.cyc_cnt = '0;
      if (st.sec_cnt + 5'h01 >= st.dwell_s) begin
        next_st.sec_cnt = '0;
        for (int k = NCH - 1; k >= 1; k--) begin
          if (st.shown_mask[3'(st.cur + 3'(k))]) begin
            next_st.cur = 3'(st.cur + 3'(k));
          end
        end
      end else begin
        next_st.sec_cnt = st.sec_cnt + 5'h01;
      end
    end else begin
      next_st.cyc_cnt = st.cyc_cnt + 25'h1;
    end
    // text scroll across the visible field
    if (st.scr_cnt == 24'(SCR_CYC - 1)) begin
      next_st.scr_cnt = '0;
      if (text_len_i > 5'(TEXT_VIS) && st.text_pos + 5'(TEXT_VIS) < text_len_i
          && st.text_pos + 5'(TEXT_VIS) < 5'(TEXT_MAX)) begin
        next_st.text_pos = st.text_pos + 5'h01;
      end else begin
        next_st.text_pos = '0;
      end
    end else begin
      next_st.scr_cnt = st.scr_cnt + 24'h1;
    end
    // displayed value and its quality
    q_cur = classify(st.status[st.cur]);
    v_cur = st.value[st.cur];
    next_st.under = v_cur < range_lo_i;
    next_st.over = v_cur > range_hi_i;
    if (v_cur < range_lo_i) begin
      next_st.bar = 4'h0;
    end else begin
      next_st.bar = bar_steps(v_cur, range_lo_i, range_hi_i);
    end
    next_st.seg_val = v_cur;
    next_st.uncertain = (q_cur == QUAL_UNCERTAIN);
    next_st.bad = (q_cur == QUAL_BAD);
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.dwell_s <= DWELL_RST;
      st.shown_mask <= MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign bar_segs_o = st.bar;
  assign arrow_under_o = st.under;
  assign arrow_over_o = st.over;
  assign seg7_value_o = st.seg_val;
  assign seg7_bad_o = st.bad;
  assign seg7_chan_o = st.cur;
  assign text_pos_o = st.text_pos;
  assign text_show_chan_o = st.bad;
  assign text_chan_o = st.cur;
  assign sym_uncertain_o = st.uncertain;
  assign sym_locked_o = st.lock;
  assign sym_comm_o = st.comm;
  assign write_lock_o = st.lock;
  assign par_rej_o = st.rej;
  assign par_ack_o = st.ack;
  assign seen_addr_o = st.seen_addr;
  assign seen_valid_o = st.seen_valid;
  ////////////////////////////////////////////////////////////////////
  property p_reject;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      par_wr_i && wp_level |=> par_rej_o && !par_ack_o;
  endproperty
  a_reject: assert property (p_reject) else $error("write accepted while locked");
  property p_lock;
    @(posedge ref_clk_i) disable iff (sys_rst_i) wp_level |=> write_lock_o && sym_locked_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock status not shown");
  property p_bar_max;
    @(posedge ref_clk_i) disable iff (sys_rst_i) bar_segs_o <= 4'(BAR_STEPS);
  endproperty
  a_bar_max: assert property (p_bar_max) else $error("bar above ten segments");
  property p_under;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      arrow_under_o |-> bar_segs_o == 4'h0 && !arrow_over_o;
  endproperty
  a_under: assert property (p_under) else $error("under arrow with bar lit");
  property p_good;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      st.status[st.cur] >= STATUS_GOOD_MIN && $stable(st.cur) ##1 $stable(st.cur)
      |-> !sym_uncertain_o && !seg7_bad_o;
  endproperty
  a_good: assert property (p_good) else $error("symbol lit on good status");
  property p_unc;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      sym_uncertain_o |-> !seg7_bad_o;
  endproperty
  a_unc: assert property (p_unc) else $error("uncertain and bad together");
  property p_bad;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      seg7_bad_o |-> text_show_chan_o && text_chan_o == seg7_chan_o;
  endproperty
  a_bad: assert property (p_bad) else $error("bad channel not in text");
  property p_dwell;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      st.dwell_s >= DWELL_MIN && st.dwell_s <= DWELL_MAX;
  endproperty
  a_dwell: assert property (p_dwell) else $error("dwell out of range");
  property p_scroll;
    @(posedge ref_clk_i) disable iff (sys_rst_i) text_pos_o + 5'(TEXT_VIS) <= 5'(TEXT_MAX);
  endproperty
  a_scroll: assert property (p_scroll) else $error("scroll past sixteen chars");

  c_reject: cover property (@(posedge ref_clk_i) par_rej_o);
  c_bad: cover property (@(posedge ref_clk_i) seg7_bad_o);
  c_unc: cover property (@(posedge ref_clk_i) sym_uncertain_o);
  c_over: cover property (@(posedge ref_clk_i) arrow_over_o);
endmodule : indicator_display

// file: sim/bus_peer.sv
/*
  far side: one device publishing values on the bus.
  assumes the bench calls publish and owns the clock.
*/
module bus_peer (
  // clock
  input wire logic ref_clk_i,
  // publication lines
  output logic pub_valid_o,
  output logic [7:0] pub_addr_o,
  output logic [15:0] pub_value_o,
  output logic [7:0] pub_status_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pub_valid_o = 1'h0;
    pub_addr_o = 8'h00;
    pub_value_o = 16'h0000;
    pub_status_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // one-cycle strobe; lines scrambled once released
  task automatic publish(input logic [7:0] a, input logic [15:0] v,
                         input logic [7:0] s, input int slow);
    @(negedge ref_clk_i);
    repeat (slow) @(negedge ref_clk_i);
    pub_addr_o <= a;
    pub_value_o <= v;
    pub_status_o <= s;
    pub_valid_o <= 1'h1;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    pub_valid_o <= 1'h0;
    pub_addr_o <= ~a;
    pub_value_o <= ~v;
    pub_status_o <= ~s;
  endtask : publish
endmodule : bus_peer

// file: sim/indicator_display_tb.sv
/*
  bench for the indicator display logic.
  assumes bus_peer on the publication port, 20 MHz clock.
*/
module indicator_display_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'h0, sys_rst_i = 1'h1, wp_switch_i = 1'h0;
  logic comm_active_i = 1'h0, fb_valid_i = 1'h0, par_wr_i = 1'h0;
  logic [2:0] fb_chan_i = 3'h0;
  logic [15:0] fb_value_i = 16'h0000;
  logic [7:0] fb_status_i = 8'h00, par_data_i = 8'h00;
  logic [3:0] par_sel_i = 4'h0;
  logic [15:0] range_lo_i = 16'h0064, range_hi_i = 16'h044c;
  logic [4:0] text_len_i = 5'h10;
  logic pub_valid_i;
  logic [7:0] pub_addr_i, pub_status_i, seen_addr_o;
  logic [15:0] pub_value_i, seg7_value_o;
  logic [3:0] bar_segs_o;
  logic arrow_under_o, arrow_over_o, seg7_bad_o, text_show_chan_o;
  logic sym_uncertain_o, sym_locked_o, sym_comm_o, write_lock_o;
  logic par_rej_o, par_ack_o, seen_valid_o;
  logic [2:0] seg7_chan_o, text_chan_o;
  logic [4:0] text_pos_o;
  int bad_count = 0, cmp_count = 0;
  // short second and scroll step keep cycling and scrolling testable
  localparam int unsigned SEC_CYC = 20;
  localparam int unsigned SCR_STEP = 10;
  logic [15:0] vals [8] = '{16'h0032, 16'h0064, 16'h00c7, 16'h00c8,
                            16'h028a, 16'h044b, 16'h044c, 16'h04b0};
  logic [7:0] stats [8] = '{8'h80, 8'hff, 8'h7f, 8'h40, 8'h3f, 8'h00, 8'h80, 8'h41};

  always #25 ref_clk_i = ~ref_clk_i;

  indicator_display #(.CYC_SEC(SEC_CYC), .SCR_CYC(SCR_STEP)) dut_u (.ref_clk_i, .sys_rst_i,
    .wp_switch_i, .pub_valid_i,
    .pub_addr_i, .pub_value_i, .pub_status_i, .comm_active_i, .fb_valid_i,
    .fb_chan_i, .fb_value_i, .fb_status_i, .par_wr_i, .par_sel_i, .par_data_i,
    .range_lo_i, .range_hi_i, .text_len_i, .bar_segs_o, .arrow_under_o,
    .arrow_over_o, .seg7_value_o, .seg7_bad_o, .seg7_chan_o, .text_pos_o,
    .text_show_chan_o, .text_chan_o, .sym_uncertain_o, .sym_locked_o,
    .sym_comm_o, .write_lock_o, .par_rej_o, .par_ack_o, .seen_addr_o,
    .seen_valid_o);
  bus_peer peer_u (.ref_clk_i, .pub_valid_o(pub_valid_i), .pub_addr_o(pub_addr_i),
    .pub_value_o(pub_value_i), .pub_status_o(pub_status_i));
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [3:0] exp_bar(input int v);
    if (v < 100) return 4'h0;
    if ((v - 100) * 10 / 1000 > 10) return 4'ha;
    return 4'((v - 100) * 10 / 1000);
  endfunction : exp_bar

  task automatic par_write(input logic [3:0] s, input logic [7:0] d);
    @(negedge ref_clk_i);
    par_sel_i = s;
    par_data_i = d;
    par_wr_i = 1'h1;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    par_wr_i = 1'h0;
  endtask : par_write

  task automatic disp(input logic [15:0] v, input logic [7:0] s);
    chk("bar", exp_bar(v), bar_segs_o);
    chk("under", v < 16'h0064, arrow_under_o);
    chk("over", v > 16'h044c, arrow_over_o);
    chk("uncertain", s >= 8'h40 && s < 8'h80, sym_uncertain_o);
    chk("bad", s < 8'h40, seg7_bad_o);
    chk("text_chan_on", s < 8'h40, text_show_chan_o);
    if (s >= 8'h40) chk("value", v, seg7_value_o);
    else chk("chan", 16'h0000, {seg7_chan_o, text_chan_o});
  endtask : disp

  task automatic pub_check(input logic [7:0] a, input logic [15:0] v,
                           input logic [7:0] s, input int slow);
    peer_u.publish(a, v, s, slow);
    chk("seen_valid", 16'h0001, seen_valid_o);
    chk("seen_addr", a, seen_addr_o);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    disp(v, s);
  endtask : pub_check

  task automatic wait_lock(input logic l);
    int n;
    for (n = 0; n < 16 && write_lock_o !== l; n++) @(negedge ref_clk_i);
    if (n == 16) begin
      bad_count++;
      close_out();
    end
    chk("write_lock", l, write_lock_o);
    chk("locked_sym", l, sym_locked_o);
  endtask : wait_lock

  task automatic wait_chan(input logic [2:0] c, output int n);
    for (n = 0; n < 1000 && seg7_chan_o !== c; n++) @(negedge ref_clk_i);
    if (n == 1000) begin
      bad_count++;
      close_out();
    end
    chk("shown_chan", 16'(c), 16'(seg7_chan_o));
  endtask : wait_chan

  task automatic wait_pos(input logic [4:0] p, output int n);
    for (n = 0; n < 200 && text_pos_o !== p; n++) @(negedge ref_clk_i);
    if (n == 200) begin
      bad_count++;
      close_out();
    end
    chk("text_pos", 16'(p), 16'(text_pos_o));
  endtask : wait_pos
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    close_out();
  end

  initial begin
    int n;
    repeat (20) @(negedge ref_clk_i);
    sys_rst_i = 1'h0;
    repeat (2) @(negedge ref_clk_i);
    chk("lock_rst", 16'h0000, write_lock_o);
    chk("bad_rst", 16'h0001, seg7_bad_o);
    par_write(4'h0, 8'h20);
    chk("ack", 16'h0001, par_ack_o);
    chk("rej", 16'h0000, par_rej_o);
    for (int i = 0; i < 8; i++) pub_check(8'h20, vals[i], stats[i], i % 2);
    peer_u.publish(8'h55, 16'h0123, 8'h80, 0);
    repeat (2) @(negedge ref_clk_i);
    chk("unbound", vals[7], seg7_value_o);
    $display("test listener done");
    wp_switch_i = 1'h1;
    wait_lock(1'h1);
    par_write(4'h0, 8'h30);
    chk("rej_wp", 16'h0001, par_rej_o);
    chk("ack_wp", 16'h0000, par_ack_o);
    pub_check(8'h20, 16'h0190, 8'h80, 0);
    wp_switch_i = 1'h0;
    wait_lock(1'h0);
    comm_active_i = 1'h1;
    repeat (2) @(negedge ref_clk_i);
    chk("comm", 16'h0001, sym_comm_o);
    comm_active_i = 1'h0;
    $display("test protect done");
    par_write(4'ha, 8'h01);
    chk("ack_mode", 16'h0001, par_ack_o);
    fb_value_i = 16'h0384;
    fb_status_i = 8'h60;
    fb_valid_i = 1'h1;
    @(negedge ref_clk_i);
    fb_valid_i = 1'h0;
    fb_value_i = 16'hfc7b;
    @(negedge ref_clk_i);
    disp(16'h0384, 8'h60);
    peer_u.publish(8'h20, 16'h0064, 8'h80, 0);
    chk("seen_fb", 16'h0000, seen_valid_o);
    @(negedge ref_clk_i);
    chk("value_fb", 16'h0384, seg7_value_o);
    $display("test block mode done");
    par_write(4'h8, 8'h05);
    chk("ack_mask", 16'h0001, par_ack_o);
    par_write(4'h9, 8'h01);
    wait_chan(3'h2, n);
    wait_chan(3'h0, n);
    chk("dwell_min", 16'(2 * SEC_CYC), 16'(n));
    par_write(4'h9, 8'h15);
    wait_chan(3'h2, n);
    wait_chan(3'h0, n);
    chk("dwell_max", 16'(20 * SEC_CYC), 16'(n));
    $display("test cycling done");
    wait_pos(5'h08, n);
    wait_pos(5'h00, n);
    chk("scroll_step", 16'(SCR_STEP), 16'(n));
    wait_pos(5'h03, n);
    text_len_i = 5'h08;
    repeat (40) @(negedge ref_clk_i);
    chk("no_scroll", 16'h0000, text_pos_o);
    $display("test scroll done");
    close_out();
  end
endmodule : indicator_display_tb
